/* File: rtl/socr_clk_phase.sv */
// module: picks one phase of the global clock divider for the output clocks
module socr_clk_phase #(
  parameter int NPH = socr_pkg::PHASE_COUNT
) (
  input  wire logic             clk,          // system clock
  input  wire logic             rst,          // async reset, active high
  input  wire logic [3:0]       phase_code,   // selected phase code
  input  wire logic [NPH-1:0]   bit_phases,   // divider phases for the bit-rate clock
  input  wire logic [NPH-1:0]   word_phases,  // divider phases for the word clock
  output logic                  bit_clk_out,  // bit_rate_clock_out
  output logic                  word_clk_out  // word_boundary_clock_out
);

  typedef struct packed {
    logic bit_clk;
    logic word_clk;
  } socr_ph_state_t;

  socr_ph_state_t s_q, s_d;
  logic [3:0]     sel;

  assign bit_clk_out  = s_q.bit_clk;
  assign word_clk_out = s_q.word_clk;

  always_comb begin
    // reserved codes fall back to the reset phase rather than an undefined tap
    sel        = (phase_code > socr_pkg::PHASE_CODE_MAX) ? socr_pkg::RST_CLK_PHASE : phase_code;
    s_d.bit_clk  = bit_phases[sel];  // R09
    s_d.word_clk = word_phases[sel]; // R09
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

/* File: rtl/socr_pkg.sv */
// package: offsets, field positions, reset values and codes of the serial output configuration registers
package socr_pkg;

  // ************************************************************
  // register addresses on the serial control port
  // ************************************************************
  localparam logic [12:0] ADDR_SAMPLE_FORMAT  = 13'h0014;
  localparam logic [12:0] ADDR_DRIVER_TERM    = 13'h0015;
  localparam logic [12:0] ADDR_CLK_PHASE      = 13'h0016;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_SAMPLE_FORMAT    = 8'h00;
  localparam logic [7:0] RST_DRIVER_TERM      = 8'h00;
  localparam logic [3:0] RST_CLK_PHASE        = 4'h3;

  // ************************************************************
  // sample_format_control fields
  // ************************************************************
  localparam int FMT_LSB                      = 0;
  localparam int FMT_MSB                      = 1;
  localparam int INVERT_BIT                   = 2;
  localparam int LOW_SWING_BIT                = 6;
  localparam logic [1:0] FMT_OFFSET_BINARY    = 2'h0;
  localparam logic [1:0] FMT_TWOS_COMPLEMENT  = 2'h1;
  localparam logic [7:0] FORMAT_GLOBAL_MASK   = 8'hfb;

  // ************************************************************
  // driver_termination_control fields
  // ************************************************************
  localparam int DRIVE_2X_BIT                 = 0;
  localparam int TERM_LSB                     = 4;
  localparam int TERM_MSB                     = 5;
  localparam logic [1:0] TERM_NONE            = 2'h0;
  localparam logic [1:0] TERM_200_OHM         = 2'h1;
  localparam logic [7:0] DRIVER_GLOBAL_MASK   = 8'hfe;

  // ************************************************************
  // clock_phase_select field
  // ************************************************************
  localparam int PHASE_W                      = 4;
  localparam logic [3:0] PHASE_CODE_MAX       = 4'ha;
  localparam int PHASE_COUNT                  = 11;

  // ************************************************************
  // serial control port framing
  // ************************************************************
  localparam int INSTR_BITS                   = 16;
  localparam int DATA_BITS                    = 8;
  localparam int FRAME_BITS                   = 24;
  localparam int RW_BIT                       = 15;

  typedef enum logic [1:0] {
    SOCR_TERM_OFF,
    SOCR_TERM_200,
    SOCR_TERM_100
  } socr_term_t;

endpackage

/* File: rtl/socr_reg_if.sv */
// interface: register access strobe, address and data between serial port and register bank
interface socr_reg_if;
  logic        wr_stb;
  logic [12:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;

  modport port (output wr_stb, output addr, output wdata, input rdata);
  modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface

/* File: rtl/socr_regs.sv */
// module: serial output configuration register bank with per-channel sample encoding
// Operation
// [R01] format field bits 1:0: 00 offset binary default, 01 two's complement
// [R02] invert bit set inverts the addressed channel's output data, default off
// [R03] format bits 7:3 and 1:0 global; bit 2 only for addressed channels
// [R04] format bit 6: 0 standard swing differential, 1 reduced-swing low power
// [R05] termination bits 5:4: 00 none, 01 200 ohm, 10 and 11 100 ohm
// [R06] adjust bit 0 doubles clock output drive per channel; bits 7:1 global
// [R07] phase field takes codes 0000 to 1010, 60 degree steps up to 600
// [R08] after reset phase code is 0011, a 180 degree offset
// [R09] phase code picks which global divider phase drives the output clock
// [R10] phase setting never moves internal data latching, only the output clock
// [R11] host writes only codes up to 1010; higher codes are reserved
module socr_regs #(
  parameter int NCH = 8,
  parameter int SW  = 12,
  parameter int NPH = socr_pkg::PHASE_COUNT
) (
  input  wire logic              clk,          // system clock, 50 MHz
  input  wire logic              rst,          // async reset, active high
  input  wire logic              sclk,         // serial port clock
  input  wire logic              csb_n,        // serial port select, active low
  input  wire logic              sdio_i,       // serial data in
  output logic                   sdio_o,       // serial data out
  output logic                   sdio_oe,      // serial data drive enable
  input  wire logic [NCH-1:0]    chan_sel,     // channels addressed for local bits
  input  wire logic [NCH*SW-1:0] sample_in,    // raw offset-binary samples
  output logic [NCH*SW-1:0]      sample_out,   // encoded samples to serializer
  output logic                   low_swing,    // reduced-swing output mode
  output socr_pkg::socr_term_t   term_sel,     // internal termination setting
  output logic [NCH-1:0]         drive_2x,     // double drive of clock outputs
  output logic [3:0]             phase_code,   // current phase code
  input  wire logic [NPH-1:0]    bit_phases,   // divider phases, bit clock
  input  wire logic [NPH-1:0]    word_phases,  // divider phases, word clock
  output logic                   bit_rate_clock_out,     // phase-selected bit clock
  output logic                   word_boundary_clock_out // phase-selected word clock
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0]        fmt_glob;
    logic [NCH-1:0]    invert;
    logic [7:0]        drv_glob;
    logic [NCH-1:0]    drive;
    logic [3:0]        phase;
    logic [NCH*SW-1:0] samples;
  } socr_state_t;

  socr_state_t s_q, s_d;
  socr_reg_if  bus ();

  // local bit readback shows the lowest addressed channel
  function automatic logic first_sel(input logic [NCH-1:0] v, input logic [NCH-1:0] sel);
    logic r;
    logic hit;
    r   = 1'b0;
    hit = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (sel[i] && !hit) begin
        r   = v[i];
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  // ************************************************************
  // serial port and output clock phase
  // ************************************************************
  socr_serial_port u_port (
    .clk     (clk),
    .rst     (rst),
    .sclk    (sclk),
    .csb_n   (csb_n),
    .sdio_i  (sdio_i),
    .sdio_o  (sdio_o),
    .sdio_oe (sdio_oe),
    .bus     (bus.port)
  );

  socr_clk_phase #(.NPH(NPH)) u_phase (
    .clk          (clk),
    .rst          (rst),
    .phase_code   (s_q.phase),
    .bit_phases   (bit_phases),
    .word_phases  (word_phases),
    .bit_clk_out  (bit_rate_clock_out),
    .word_clk_out (word_boundary_clock_out)
  );

  // ************************************************************
  // register writes and sample encoding
  // ************************************************************
  always_comb begin
    s_d = s_q;
    if (bus.wr_stb) begin
      unique case (bus.addr)
        socr_pkg::ADDR_SAMPLE_FORMAT: begin
          s_d.fmt_glob = bus.wdata & socr_pkg::FORMAT_GLOBAL_MASK; // R03
          for (int c = 0; c < NCH; c++) begin
            if (chan_sel[c]) begin
              s_d.invert[c] = bus.wdata[socr_pkg::INVERT_BIT]; // R03
            end
          end
        end
        socr_pkg::ADDR_DRIVER_TERM: begin
          s_d.drv_glob = bus.wdata & socr_pkg::DRIVER_GLOBAL_MASK; // R06
          for (int c = 0; c < NCH; c++) begin
            if (chan_sel[c]) begin
              s_d.drive[c] = bus.wdata[socr_pkg::DRIVE_2X_BIT]; // R06
            end
          end
        end
        socr_pkg::ADDR_CLK_PHASE: begin
          s_d.phase = bus.wdata[socr_pkg::PHASE_W-1:0]; // R07
        end
        default: begin
        end
      endcase
    end
    // samples are registered on clk alone, so the phase code cannot shift their timing
    for (int c = 0; c < NCH; c++) begin // R10
      logic [SW-1:0] v;
      v = sample_in[c*SW +: SW];
      if (s_q.fmt_glob[socr_pkg::FMT_MSB:socr_pkg::FMT_LSB] == socr_pkg::FMT_TWOS_COMPLEMENT) begin
        v[SW-1] = ~v[SW-1]; // R01
      end
      if (s_q.invert[c]) begin
        v = ~v; // R02
      end
      s_d.samples[c*SW +: SW] = v;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q.fmt_glob <= socr_pkg::RST_SAMPLE_FORMAT;
      s_q.invert   <= '0;
      s_q.drv_glob <= socr_pkg::RST_DRIVER_TERM;
      s_q.drive    <= '0;
      s_q.phase    <= socr_pkg::RST_CLK_PHASE; // R08
      s_q.samples  <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // readback and decoded outputs
  // ************************************************************
  always_comb begin
    unique case (bus.addr)
      socr_pkg::ADDR_SAMPLE_FORMAT: begin
        bus.rdata = s_q.fmt_glob;
        bus.rdata[socr_pkg::INVERT_BIT] = first_sel(s_q.invert, chan_sel);
      end
      socr_pkg::ADDR_DRIVER_TERM: begin
        bus.rdata = s_q.drv_glob;
        bus.rdata[socr_pkg::DRIVE_2X_BIT] = first_sel(s_q.drive, chan_sel);
      end
      socr_pkg::ADDR_CLK_PHASE: begin
        bus.rdata = {4'h0, s_q.phase};
      end
      default: begin
        bus.rdata = 8'h00;
      end
    endcase
  end

  always_comb begin
    unique case (s_q.drv_glob[socr_pkg::TERM_MSB:socr_pkg::TERM_LSB]) // R05
      socr_pkg::TERM_NONE:    term_sel = socr_pkg::SOCR_TERM_OFF;
      socr_pkg::TERM_200_OHM: term_sel = socr_pkg::SOCR_TERM_200;
      default:                term_sel = socr_pkg::SOCR_TERM_100;
    endcase
  end

  assign low_swing  = s_q.fmt_glob[socr_pkg::LOW_SWING_BIT]; // R04
  assign drive_2x   = s_q.drive; // R06
  assign phase_code = s_q.phase;
  assign sample_out = s_q.samples;

endmodule

/* File: rtl/socr_serial_port.sv */
// module: serial control port slave, 16-bit instruction then one data byte, msb first
module socr_serial_port (
  input  wire logic clk,        // system clock
  input  wire logic rst,        // async reset, active high
  input  wire logic sclk,       // serial clock, synchronous to clk
  input  wire logic csb_n,      // chip select, active low
  input  wire logic sdio_i,     // serial data in
  output logic      sdio_o,     // serial data out
  output logic      sdio_oe,    // high while driving sdio
  socr_reg_if.port  bus         // register access
);

  typedef struct packed {
    logic        sclk_prev;
    logic [4:0]  cnt;
    logic [15:0] instr;
    logic [7:0]  wsh;
    logic [7:0]  rsh;
    logic        load;
    logic        oe;
    logic        wr;
  } socr_sp_state_t;

  socr_sp_state_t s_q, s_d;
  logic           rise;

  assign rise        = sclk && !s_q.sclk_prev;
  assign bus.wr_stb  = s_q.wr;
  assign bus.addr    = s_q.instr[12:0];
  assign bus.wdata   = s_q.wsh;
  assign sdio_o      = s_q.rsh[7];
  assign sdio_oe     = s_q.oe;

  always_comb begin
    s_d           = s_q;
    s_d.sclk_prev = sclk;
    s_d.wr        = 1'b0;
    s_d.load      = 1'b0;
    if (csb_n) begin
      // deselect aborts any partial frame and releases the line
      s_d.cnt = 5'h00;
      s_d.oe  = 1'b0;
    end else if (s_q.load) begin
      s_d.rsh = bus.rdata;
      s_d.oe  = s_q.instr[socr_pkg::RW_BIT];
    end else if (rise && s_q.cnt < 5'(socr_pkg::FRAME_BITS)) begin
      s_d.cnt = s_q.cnt + 5'h01;
      if (s_q.cnt < 5'(socr_pkg::INSTR_BITS)) begin
        s_d.instr = {s_q.instr[14:0], sdio_i};
        s_d.load  = (s_q.cnt == 5'(socr_pkg::INSTR_BITS - 1));
      end else begin
        s_d.wsh = {s_q.wsh[6:0], sdio_i};
        s_d.rsh = {s_q.rsh[6:0], 1'b0};
        if (s_q.cnt == 5'(socr_pkg::FRAME_BITS - 1)) begin
          s_d.wr = !s_q.instr[socr_pkg::RW_BIT];
          s_d.oe = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

/* File: verification/serial_output_config_regs_test.sv */
// testbench: register access, sample encoding, local bits and reset
module serial_output_config_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed { logic [7:0] a; logic [7:0] wd; logic [7:0] rd; } socr_row_t;
  localparam logic [11:0] RAW = 12'h3a5;
  localparam logic [11:0] TWO = RAW ^ 12'h800;
  logic clk, rst, sclk, csb_n, sdio, sdio_w, sdio_o, sdio_oe, bco, wco;
  logic [7:0] chan_sel, drive_2x, d;
  logic [95:0] sample_in, sample_out;
  logic low_swing;
  socr_pkg::socr_term_t term_sel;
  logic [3:0] phase_code;
  logic [1:0] tap;
  logic [10:0] bit_phases, word_phases;
  int error_cnt = 0;
  int n_tests = 0;
  // ****
  // ordinary cases, written with every channel addressed
  // ****
  socr_row_t rows [10] = '{'{8'h14, 8'h41, 8'h41}, '{8'h14, 8'h01, 8'h01}, '{8'h14, 8'h00, 8'h00},
    '{8'h15, 8'h31, 8'h31}, '{8'h15, 8'h20, 8'h20}, '{8'h15, 8'h10, 8'h10}, '{8'h16, 8'h0a, 8'h0a},
    '{8'h16, 8'hf5, 8'h05}, '{8'h16, 8'h00, 8'h00}, '{8'h17, 8'h5a, 8'h00}};
  assign sdio_w = sdio_oe ? sdio_o : sdio;
  socr_regs socr_regs_inst (.clk(clk), .rst(rst), .sclk(sclk), .csb_n(csb_n), .sdio_i(sdio_w),
    .sdio_o(sdio_o), .sdio_oe(sdio_oe), .chan_sel(chan_sel), .sample_in(sample_in),
    .sample_out(sample_out), .low_swing(low_swing), .term_sel(term_sel), .drive_2x(drive_2x),
    .phase_code(phase_code), .bit_phases(bit_phases), .word_phases(word_phases),
    .bit_rate_clock_out(bco), .word_boundary_clock_out(wco));
  socr_host socr_host_inst (.clk(clk), .sclk(sclk), .csb_n(csb_n), .sdio(sdio), .sdio_w(sdio_w));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    bit_phases <= {bit_phases[9:0], ~bit_phases[10]};
    word_phases <= {word_phases[9:0], ~word_phases[8]};
  end
  task automatic check(input logic [95:0] got, input logic [95:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    socr_host_inst.xfer({8'h00, a}, v, d);
  endtask
  task automatic rd(input logic [7:0] a);
    socr_host_inst.xfer({8'h80, a}, 8'h00, d);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #500us;
    error_cnt++;
    close_out();
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    chan_sel = 8'hff;
    sample_in = {8{RAW}};
    bit_phases = 11'h2b5;
    word_phases = 11'h54a;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    // host keeps phase codes within 0000..1010
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].wd);
      rd(rows[i].a);
      check(d, rows[i].rd);
      case (rows[i].a)
        8'h14: check(low_swing, rows[i].wd[6]);
        8'h15: check(term_sel, rows[i].wd[5:4] == 2'h0 ? 0 : (rows[i].wd[5:4] == 2'h1 ? 1 : 2));
        8'h16: check(phase_code, rows[i].wd[3:0]);
        default: check(drive_2x, 8'h00);
      endcase
    end
    $display("test rows done");
    @(posedge clk) chan_sel <= 8'h01;
    wr(8'h14, 8'h05);
    check(sample_out[11:0], {~TWO});
    check(sample_out[23:12], TWO);
    @(posedge clk) chan_sel <= 8'h02;
    rd(8'h14);
    check(d, 8'h01);
    $display("test local invert done");
    @(posedge clk) chan_sel <= 8'h80;
    wr(8'h15, 8'h01);
    check(drive_2x, 8'h80);
    $display("test local drive done");
    // tap seen before an edge must show on the output clocks one edge later
    wr(8'h16, 8'h07);
    repeat (3) begin
      @(posedge clk) tap = {word_phases[7], bit_phases[7]};
      @(posedge clk) check({wco, bco}, tap);
    end
    // sample latency stays one clk whatever the phase code
    @(posedge clk) sample_in <= {8{TWO}};
    @(posedge clk) check(sample_out[23:12], TWO);
    check(phase_code, 4'h7);
    @(posedge clk) check(sample_out[23:12], RAW);
    $display("test phase tap done");
    @(posedge clk) rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check(phase_code, 4'h3);
    check(sample_out[23:12], TWO);
    rd(8'h16);
    check(d, 8'h03);
    rd(8'h14);
    check(d, 8'h00);
    $display("test reset done");
    close_out();
  end
endmodule

/* File: verification/socr_host.sv */
// partner model: serial control port host, sclk idles low between frames
module socr_host (
  input  wire logic clk,    // system clock
  output logic      sclk,   // serial clock
  output logic      csb_n,  // select, active low
  output logic      sdio,   // data toward device
  input  wire logic sdio_w  // resolved data line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rel = 1'b0;
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    sdio = 1'b0;
  end
  // released line toggles so a stale bit never passes for read data
  always @(posedge clk) if (rel) sdio <= ~sdio;
  // ****
  // one frame: 16 instruction bits, 8 data bits, 2 clk low and 3 clk high per bit
  // ****
  task automatic xfer(input logic [15:0] ins, input logic [7:0] wd, output logic [7:0] rd);
    logic [23:0] f;
    f = {ins, wd};
    rd = 8'h00;
    @(posedge clk) csb_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(posedge clk);
      sclk <= 1'b0;
      if (ins[15] && i < 8) rel <= 1'b1;
      else sdio <= f[i];
      repeat (2) @(posedge clk);
      sclk <= 1'b1;
      if (i < 8) rd[i] = sdio_w;
      repeat (2) @(posedge clk);
    end
    @(posedge clk) sclk <= 1'b0;
    @(posedge clk);
    csb_n <= 1'b1;
    rel <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule

/* File: verification/socr_regs_sva.sv */
// checker: port-level assertions for the serial output configuration registers
module socr_regs_sva #(
  parameter int NCH = 8,
  parameter int SW  = 12,
  parameter int NPH = socr_pkg::PHASE_COUNT
) (
  input wire logic                 clk,                     // system clock
  input wire logic                 rst,                     // async reset
  input wire logic                 sclk,                    // serial clock
  input wire logic                 csb_n,                   // select, active low
  input wire logic                 sdio_i,                  // serial data in
  input wire logic                 sdio_o,                  // serial data out
  input wire logic                 sdio_oe,                 // serial drive enable
  input wire logic [NCH-1:0]       chan_sel,                // channel mask
  input wire logic [NCH*SW-1:0]    sample_in,               // raw samples
  input wire logic [NCH*SW-1:0]    sample_out,              // encoded samples
  input wire logic                 low_swing,               // reduced swing
  input wire socr_pkg::socr_term_t term_sel,                // termination
  input wire logic [NCH-1:0]       drive_2x,                // double drive
  input wire logic [3:0]           phase_code,              // phase code
  input wire logic [NPH-1:0]       bit_phases,              // bit clock taps
  input wire logic [NPH-1:0]       word_phases,             // word clock taps
  input wire logic                 bit_rate_clock_out,      // bit clock out
  input wire logic                 word_boundary_clock_out  // word clock out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // helper: one-cycle model of the sample path and tap choice
  // ****
  logic [NCH*SW-1:0] sin_q;
  logic              bit_q;
  logic              word_q;
  logic [3:0]        idx;
  logic [SW-1:0]     d;
  logic              tf;
  logic              fmt_ok;
  // reserved codes fall back to the 180 degree tap
  assign idx = (phase_code > socr_pkg::PHASE_CODE_MAX) ? 4'h3 : phase_code;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sin_q <= '0;
      bit_q <= 1'b0;
      word_q <= 1'b0;
    end else begin
      sin_q <= sample_in;
      bit_q <= bit_phases[idx];
      word_q <= word_phases[idx];
    end
  end
  // each channel differs from its input only by msb flip and/or full invert; msb flip shared
  always_comb begin
    fmt_ok = 1'b1;
    d = sample_out[SW-1:0] ^ sin_q[SW-1:0];
    tf = d[SW-1] ^ d[SW-2];
    for (int c = 0; c < NCH; c++) begin
      d = sample_out[c*SW +: SW] ^ sin_q[c*SW +: SW];
      if (d[SW-2:0] != {(SW-1){d[SW-2]}}) fmt_ok = 1'b0;
      if ((d[SW-1] ^ d[SW-2]) != tf) fmt_ok = 1'b0;
    end
  end
  // ****
  // assertions
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence out_of_reset; $fell(rst); endsequence
  sequence sel_idle; csb_n ##1 csb_n; endsequence
  chk_phase_default: assert property (out_of_reset |-> phase_code == socr_pkg::RST_CLK_PHASE)
    else $error("phase code not at default after reset");
  chk_cfg_default: assert property (out_of_reset |-> !low_swing && term_sel == socr_pkg::SOCR_TERM_OFF)
    else $error("output config not at default after reset");
  chk_bit_tap: assert property (bit_rate_clock_out == bit_q)
    else $error("bit clock not from selected tap");
  chk_word_tap: assert property (word_boundary_clock_out == word_q)
    else $error("word clock not from selected tap");
  chk_format_global: assert property (fmt_ok)
    else $error("sample encoding inconsistent");
  chk_cfg_quiet: assert property (!$stable({low_swing, term_sel, phase_code}) |-> !$past(csb_n))
    else $error("config changed outside a frame");
  chk_drive_local: assert property (((drive_2x ^ $past(drive_2x)) & ~$past(chan_sel)) == '0)
    else $error("drive bit changed on unaddressed channel");
  chk_oe_release: assert property (sel_idle |-> !sdio_oe)
    else $error("serial data driven while deselected");
endmodule

bind socr_regs socr_regs_sva #(.NCH(NCH), .SW(SW), .NPH(NPH)) socr_regs_sva_inst (
  .clk(clk), .rst(rst), .sclk(sclk), .csb_n(csb_n), .sdio_i(sdio_i), .sdio_o(sdio_o),
  .sdio_oe(sdio_oe), .chan_sel(chan_sel), .sample_in(sample_in), .sample_out(sample_out),
  .low_swing(low_swing), .term_sel(term_sel), .drive_2x(drive_2x), .phase_code(phase_code),
  .bit_phases(bit_phases), .word_phases(word_phases), .bit_rate_clock_out(bit_rate_clock_out),
  .word_boundary_clock_out(word_boundary_clock_out));
